// File: shared/i2c_short_defs.vh
// Constants for the short-transfer I2C master: SFR offsets, fields, resets.
// Assumes an 8-bit SFR bus with 16-bit addresses in the 0xFF80 page.
`ifndef I2C_SHORT_DEFS_VH
`define I2C_SHORT_DEFS_VH

// Register offsets
`define OFS_SLAVE_ADDRESS_DIR 16'hFF80
`define OFS_WRITE_BYTE_FIRST 16'hFF81
`define OFS_WRITE_BYTE_SECOND 16'hFF82
`define OFS_READ_BYTE_FIRST 16'hFF83
`define OFS_READ_BYTE_SECOND 16'hFF84
`define OFS_TRANSFER_CTRL_STATUS 16'hFF85
`define OFS_EXT_IRQ6_CONTROL 16'hFF95

// Reset values
`define RST_BYTE 8'h00

// Control/status fields
`define BIT_TWO_BYTE_SELECT 0
`define BIT_LAUNCH_BUSY 1
`define BIT_NACK_ERROR 2

// Interrupt control fields
`define BIT_TRANSFER_DONE_FLAG 2
`define BIT_TRANSFER_DONE_IRQ_EN 3

// Slave address field
`define BIT_DIRECTION 0

// Time base: one tick per quarter of an SCL period (1.6 MHz from 400 kHz)
`define SCL_RATE_KHZ 400
`define TICKS_PER_BIT 4

`endif

// File: hw/i2c_quarter_tick.v
// Quarter-bit tick generator for the short-transfer I2C master.
// Assumes a time-base clock level tb_clk synchronous to clock.
// Emits four phase pulses per tb_clk period: both edges plus midpoints.
`include "i2c_short_defs.vh"

module i2c_quarter_tick #(
    parameter CW = 8
) (
    // Clock and reset
    input wire clock,
    input wire nrst,
    // Time base level
    input wire tb_clk,
    // Phase pulse out
    output reg tick
);

    reg tb_prev_r; // Last time-base level
    reg [CW-1:0] half_cnt_r; // Cycles in last half period
    reg [CW-1:0] cnt_r; // Cycles since last edge
    wire edge_seen; // Time-base edge this cycle

    assign edge_seen = tb_clk ^ tb_prev_r;

    // Tick on each edge and at the midpoint of each half period
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tb_prev_r <= 1'b0;
            half_cnt_r <= {CW{1'b0}};
            cnt_r <= {CW{1'b0}};
            tick <= 1'b0;
        end else begin
            tb_prev_r <= tb_clk;
            if (edge_seen) begin
                half_cnt_r <= cnt_r;
                cnt_r <= {CW{1'b0}};
                tick <= 1'b1;
            end else begin
                if (cnt_r != {CW{1'b1}}) begin
                    cnt_r <= cnt_r + 1'b1;
                end
                tick <= (half_cnt_r != {CW{1'b0}}) &&
                        (cnt_r == (half_cnt_r >> 1));
            end
        end
    end

endmodule

// File: hw/i2c_short_master.v
// SFR-mapped I2C master moving one or two bytes per frame.
// Assumes an 8-bit SFR bus (addr, wdata, write strobe, read strobe),
// a 400 kHz time-base level and an external open-drain bus resolver.
`include "i2c_short_defs.vh"

module i2c_short_master (
    // Clock and reset
    input wire clock,
    input wire nrst,
    // SFR bus
    input wire [15:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_wr,
    input wire sfr_rd,
    output reg [7:0] sfr_rdata,
    // Time base, 400 kHz level
    input wire tb_clk,
    // I2C pins, open drain
    input wire scl_in,
    output reg scl_out,
    output reg scl_oe,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    // External interrupt line six
    output reg ext_irq6
);

    // Frame states
    localparam ST_IDLE = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_BIT = 3'd2;
    localparam ST_ACK = 3'd3;
    localparam ST_STOP = 3'd4;

    // Software-visible registers
    reg [7:0] slave_address_dir_r; // Target address and direction
    reg [7:0] write_byte_first_r; // First byte to send
    reg [7:0] write_byte_second_r; // Second byte to send
    reg [7:0] read_byte_first_r; // First byte received
    reg [7:0] read_byte_second_r; // Second byte received
    reg two_byte_select_r; // Two-byte mode
    reg launch_busy_r; // Launch and busy
    reg nack_error_r; // Slave nack seen
    reg transfer_done_r; // Completion flag
    reg transfer_done_irq_en_r; // Completion interrupt enable

    // Frame engine
    reg [2:0] state_r; // Current frame state
    reg [1:0] phase_r; // Quarter within bit
    reg [2:0] bit_r; // Bit index, MSB first
    reg [1:0] byte_r; // 0 address, 1 first data, 2 second
    reg [7:0] shift_r; // Byte in flight
    reg [7:0] rx_r; // Assembled received bits
    wire tick; // Quarter-bit pulse
    wire is_read; // Direction of the frame
    wire last_byte; // Current byte ends the frame
    wire wr_hit_ctrl; // Control register write
    wire launch; // Start a new frame

    assign is_read = slave_address_dir_r[`BIT_DIRECTION];
    assign last_byte = (byte_r == 2'd2) ||
                       ((byte_r == 2'd1) && !two_byte_select_r);
    assign wr_hit_ctrl = sfr_wr && (sfr_addr == `OFS_TRANSFER_CTRL_STATUS);
    assign launch = wr_hit_ctrl && sfr_wdata[`BIT_LAUNCH_BUSY] &&
                    !launch_busy_r;

    // Time base feeds the engine, no SCL divider inside
    i2c_quarter_tick u_tick (
        .clock(clock),
        .nrst(nrst),
        .tb_clk(tb_clk),
        .tick(tick)
    );

    // Register writes; address and data bytes ignored while busy, IRQ enable always taken
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            slave_address_dir_r <= `RST_BYTE;
            write_byte_first_r <= `RST_BYTE;
            write_byte_second_r <= `RST_BYTE;
            transfer_done_irq_en_r <= 1'b0;
        end else if (sfr_wr) begin
            if (sfr_addr == `OFS_EXT_IRQ6_CONTROL) begin
                transfer_done_irq_en_r <=
                    sfr_wdata[`BIT_TRANSFER_DONE_IRQ_EN];
            end else if (!launch_busy_r) begin
                // Busy writes dropped to protect the frame
                case (sfr_addr)
                    `OFS_SLAVE_ADDRESS_DIR:
                        slave_address_dir_r <= sfr_wdata;
                    `OFS_WRITE_BYTE_FIRST:
                        write_byte_first_r <= sfr_wdata;
                    `OFS_WRITE_BYTE_SECOND:
                        write_byte_second_r <= sfr_wdata;
                    default: ;
                endcase
            end
        end
    end

    // Register read mux, unmapped reads as zero
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= `RST_BYTE;
        end else if (sfr_rd) begin
            case (sfr_addr)
                `OFS_SLAVE_ADDRESS_DIR: sfr_rdata <= slave_address_dir_r;
                `OFS_WRITE_BYTE_FIRST: sfr_rdata <= write_byte_first_r;
                `OFS_WRITE_BYTE_SECOND: sfr_rdata <= write_byte_second_r;
                `OFS_READ_BYTE_FIRST: sfr_rdata <= read_byte_first_r;
                `OFS_READ_BYTE_SECOND: sfr_rdata <= read_byte_second_r;
                `OFS_TRANSFER_CTRL_STATUS: begin
                    // Status view of the frame
                    sfr_rdata <= {5'h00, nack_error_r, launch_busy_r,
                                  two_byte_select_r};
                end
                `OFS_EXT_IRQ6_CONTROL: begin
                    sfr_rdata <= {4'h0, transfer_done_irq_en_r,
                                  transfer_done_r, 2'b00};
                end
                default: sfr_rdata <= `RST_BYTE;
            endcase
        end
    end

    // Frame engine: control, status and pin drive
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            two_byte_select_r <= 1'b0;
            launch_busy_r <= 1'b0;
            nack_error_r <= 1'b0;
            transfer_done_r <= 1'b0;
            ext_irq6 <= 1'b0;
            read_byte_first_r <= `RST_BYTE;
            read_byte_second_r <= `RST_BYTE;
            state_r <= ST_IDLE;
            phase_r <= 2'd0;
            bit_r <= 3'd7;
            byte_r <= 2'd0;
            shift_r <= 8'h00;
            rx_r <= 8'h00;
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            // Interrupt line follows flag and enable
            ext_irq6 <= transfer_done_r && transfer_done_irq_en_r;
            if (wr_hit_ctrl && !launch_busy_r) begin
                two_byte_select_r <= sfr_wdata[`BIT_TWO_BYTE_SELECT];
            end
            if (launch) begin
                launch_busy_r <= 1'b1;
                nack_error_r <= 1'b0;
                transfer_done_r <= 1'b0;
                state_r <= ST_START;
                phase_r <= 2'd0;
                bit_r <= 3'd7;
                byte_r <= 2'd0;
                shift_r <= slave_address_dir_r;
            end else if (tick) begin
                phase_r <= phase_r + 2'd1;
                case (state_r)
                    ST_IDLE: begin
                        // Bus released
                        scl_oe <= 1'b0;
                        sda_oe <= 1'b0;
                    end
                    ST_START: begin
                        // SDA falls while SCL high, then SCL low
                        if (phase_r == 2'd1) begin
                            sda_oe <= 1'b1;
                        end else if (phase_r == 2'd3) begin
                            scl_oe <= 1'b1;
                            state_r <= ST_BIT;
                        end
                    end
                    ST_BIT: begin
                        // SCL low on 0,3; high on 1,2 at 400 kHz
                        if (phase_r == 2'd0) begin
                            if (byte_r != 2'd0 && is_read) begin
                                sda_oe <= 1'b0;
                            end else begin
                                sda_oe <= !shift_r[bit_r];
                            end
                        end else if (phase_r == 2'd1) begin
                            scl_oe <= 1'b0;
                        end else if (phase_r == 2'd2) begin
                            rx_r <= {rx_r[6:0], sda_in};
                        end else begin
                            scl_oe <= 1'b1;
                            bit_r <= bit_r - 3'd1;
                            if (bit_r == 3'd0) begin
                                state_r <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (phase_r == 2'd0) begin
                            if (byte_r != 2'd0 && is_read) begin
                                // Ack all but the last byte
                                sda_oe <= !last_byte;
                                if (byte_r == 2'd1) begin
                                    read_byte_first_r <= rx_r;
                                end else begin
                                    read_byte_second_r <= rx_r;
                                end
                            end else begin
                                sda_oe <= 1'b0;
                            end
                        end else if (phase_r == 2'd1) begin
                            scl_oe <= 1'b0;
                        end else if (phase_r == 2'd2) begin
                            if (!(byte_r != 2'd0 && is_read) && sda_in) begin
                                nack_error_r <= 1'b1;
                            end
                        end else begin
                            scl_oe <= 1'b1;
                            bit_r <= 3'd7;
                            byte_r <= byte_r + 2'd1;
                            // Data bytes: first then second
                            shift_r <= (byte_r == 2'd0) ?
                                write_byte_first_r : write_byte_second_r;
                            state_r <= (byte_r != 2'd0 && last_byte) ?
                                ST_STOP : ST_BIT;
                        end
                    end
                    ST_STOP: begin
                        // SDA low, SCL released, then SDA rises
                        if (phase_r == 2'd0) begin
                            sda_oe <= 1'b1;
                        end else if (phase_r == 2'd1) begin
                            scl_oe <= 1'b0;
                        end else if (phase_r == 2'd3) begin
                            sda_oe <= 1'b0;
                            launch_busy_r <= 1'b0;
                            transfer_done_r <= 1'b1;
                            state_r <= ST_IDLE;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

endmodule

// File: sim/i2c_slave_model.sv
// Behavioural I2C slave on the far side of the short-transfer master.
// Assumes pulled-up SCL/SDA levels; it only ever pulls SDA low.
module i2c_slave_model (
    // Resolved bus levels
    input wire scl,
    input wire sda,
    // Refuse with nack, bytes to send
    input wire nack_en,
    input wire [15:0] rd_data,
    // Pull-down and observations
    output logic sda_oe,
    output logic [23:0] rx,
    output logic [1:0] acks,
    output int nb
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] b; // Byte on the wire
    logic dir, rdm, nak; // Frame direction, slave sending, nack seen
    // One frame per START, cut off by STOP
    initial begin
        sda_oe = 1'b0;
        rx = 24'h0;
        acks = 2'h0;
        nb = 0;
        forever begin
            @(negedge sda iff scl === 1'b1);
            nb = 0;
            nak = 1'b0;
            fork : frm
                @(posedge sda iff scl === 1'b1);
                forever begin
                    // After a master nack the slave keeps SDA released
                    rdm = nb > 0 && dir && !nak;
                    for (int i = 7; i >= 0; i--) begin
                        // Slave data changes only while SCL is low
                        if (rdm) sda_oe = !rd_data[(nb == 1) ? 8 + i : i];
                        @(posedge scl);
                        b[i] = sda;
                        @(negedge scl);
                    end
                    if (nb == 0) dir = b[0];
                    if (!rdm) rx = {rx[15:0], b};
                    sda_oe = !rdm && !nack_en; // Ack unless told to refuse
                    @(posedge scl);
                    if (rdm) begin
                        acks = {acks[0], sda};
                        nak = sda; // Nack ends the slave's turn to send
                    end
                    @(negedge scl);
                    sda_oe = 1'b0; // Released line floats high
                    nb++;
                end
            join_any
            disable frm;
            sda_oe = 1'b0;
        end
    end
endmodule

// File: sim/i2c_short_master_chk.sv
// Checker on the short-transfer I2C master top ports.
// Assumes open-drain pins pulled up; bound at the foot.
`include "i2c_short_defs.vh"
module i2c_short_master_chk (
    // Clock and reset
    input wire clock,
    input wire nrst,
    // SFR bus
    input wire [15:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_rdata,
    // Time base and pins
    input wire tb_clk,
    input wire scl_in,
    input wire scl_out,
    input wire scl_oe,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    // Interrupt
    input wire ext_irq6
);
    reg scl_oe_r, sda_oe_r; // Pins one cycle back
    reg frame_r; // Between START and STOP
    reg irq_en_r; // Copy of the enable bit
    wire transfer_ctrl_status = sfr_addr == `OFS_TRANSFER_CTRL_STATUS;
    wire launch = sfr_wr && transfer_ctrl_status && sfr_wdata[1];
    wire start_ev = sda_oe && !sda_oe_r && !scl_oe && !scl_oe_r;
    wire stop_ev = !sda_oe && sda_oe_r && !scl_oe && !scl_oe_r;
    // Frame and enable tracking
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            frame_r <= 1'b0;
            irq_en_r <= 1'b0;
        end else begin
            scl_oe_r <= scl_oe;
            sda_oe_r <= sda_oe;
            frame_r <= start_ev | (frame_r & !stop_ev);
            if (sfr_wr && sfr_addr == `OFS_EXT_IRQ6_CONTROL)
                irq_en_r <= sfr_wdata[3];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    a_pins_pull_only: assert property (!scl_out && !sda_out)
        else $error("pin output not low");
    a_launch_starts: assert property (
        launch && !frame_r |-> ##[1:400] start_ev)
        else $error("no start after launch");
    a_irq_low_frame: assert property (frame_r |-> !ext_irq6)
        else $error("irq high in frame");
    a_irq_after_stop: assert property (
        stop_ev && irq_en_r |-> ##[0:40] ext_irq6)
        else $error("no irq after stop");
    a_irq_held: assert property (
        $fell(ext_irq6) |-> $past(sfr_wr, 2) || $past(sfr_wr, 3))
        else $error("irq dropped alone");
    a_launch_drops: assert property (launch |-> ##3 !ext_irq6)
        else $error("irq kept after launch");
    a_unmapped_zero: assert property (
        sfr_rd && sfr_addr > 16'hFF85 && sfr_addr < 16'hFF95
        |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_busy_read: assert property (
        sfr_rd && transfer_ctrl_status && frame_r |=> sfr_rdata[1] && !sfr_rdata[7:3])
        else $error("busy not shown in frame");
    c_launch: cover property (launch);
    c_stop_irq: cover property (stop_ev && irq_en_r);
    c_busy_read: cover property (sfr_rd && transfer_ctrl_status && frame_r);
endmodule

bind i2c_short_master i2c_short_master_chk chk_u (
    .clock(clock), .nrst(nrst), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .tb_clk(tb_clk), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .ext_irq6(ext_irq6)
);

// File: sim/tb.sv
// Bench: SFR traffic into the master, slave model on the bus.
// Assumes the checker binds itself; the 400 kHz base is made here.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, nrst, sfr_wr, sfr_rd, tb_clk, nack_en, rd_p; // Drives
    logic [15:0] sfr_addr, rd_data; // Address, slave reply
    logic [7:0] sfr_wdata; // Write data
    logic [7:0] exp_q[$]; // Expected read data
    wire [7:0] sfr_rdata; // Read data
    wire scl_out, scl_oe, sda_out, sda_oe, s_oe, ext_irq6; // Pins
    wire [23:0] rx; // Bytes seen by slave
    wire [1:0] acks; // Master ack bits
    int nb, mismatches, num_checks, tb_cnt; // Counters
    wire scl_l = !scl_oe; // Pulled-up SCL
    wire sda_l = !(sda_oe || s_oe); // Pulled-up SDA
    i2c_short_master dut_u (
        .clock(clock), .nrst(nrst), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .tb_clk(tb_clk), .scl_in(scl_l),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_l),
        .sda_out(sda_out), .sda_oe(sda_oe), .ext_irq6(ext_irq6)
    );
    i2c_slave_model slave_u (
        .scl(scl_l), .sda(sda_l), .nack_en(nack_en), .rd_data(rd_data),
        .sda_oe(s_oe), .rx(rx), .acks(acks), .nb(nb)
    );
    // System clock, 40 ns
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Time base: 31 cycles per half period
    always @(posedge clock) begin
        #1;
        tb_cnt = (tb_cnt == 30) ? 0 : tb_cnt + 1;
        if (tb_cnt == 0) tb_clk = !tb_clk;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clock);
        #1;
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clock);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clock);
        #1;
        sfr_rd = 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] got, input logic [7:0] e);
        num_checks++;
        if (got !== e) begin
            mismatches++;
            $display("BAD %0t read %h want %h", $time, got, e);
        end
    endtask
    task automatic chk_val(input logic [23:0] got, input logic [23:0] e);
        num_checks++;
        if (got !== e) begin
            mismatches++;
            $display("BAD %0t bus %h want %h", $time, got, e);
        end
    endtask
    task automatic wait_irq;
        for (int n = 0; n < 5000 && ext_irq6 !== 1'b1; n++)
            @(posedge clock);
        chk_val({23'h0, ext_irq6}, 24'h1);
    endtask
    task automatic summarize;
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Read data is due the edge after the strobe
    always @(posedge clock) begin
        if (rd_p) chk_rd(sfr_rdata, exp_q.pop_front());
        rd_p = sfr_rd;
    end
    // Hang guard
    initial begin
        repeat (40000) @(posedge clock);
        mismatches++;
        summarize();
    end
    initial begin
        logic [7:0] ad, d1, d2;
        logic [23:0] ew;
        logic dir, two;
        {nrst, sfr_wr, sfr_rd, tb_clk, nack_en, rd_p} = 6'h0;
        {sfr_addr, rd_data, sfr_wdata} = 40'h0;
        void'($urandom(32'hE5A68BD0));
        repeat (10) @(posedge clock);
        #1 nrst = 1'b1;
        // Reset values, one unmapped place
        for (int a = 0; a < 7; a++) rd(16'hFF80 + 16'(a), 8'h00);
        rd(16'hFF95, 8'h00);
        wr(16'hFF83, 8'hA5);
        rd(16'hFF83, 8'h00);
        wr(16'hFF95, 8'h08);
        // Write/read times one/two bytes; second frame is refused
        for (int i = 0; i < 4; i++) begin
            dir = i[1];
            two = i[0];
            ad = 8'($urandom);
            d1 = 8'($urandom);
            d2 = 8'($urandom);
            rd_data = 16'($urandom);
            nack_en = (i == 1);
            wr(16'hFF80, {ad[6:0], dir});
            wr(16'hFF81, d1);
            wr(16'hFF82, d2);
            wr(16'hFF85, {6'h0, 1'b1, two});
            rd(16'hFF85, {6'h0, 1'b1, two});
            chk_val({23'h0, ext_irq6}, 24'h0);
            wr(16'hFF80, ~{ad[6:0], dir});
            rd(16'hFF95, 8'h08);
            repeat (300) @(posedge clock);
            rd(16'hFF85, {6'h0, 1'b1, two});
            wait_irq();
            rd(16'hFF85, {5'h0, (i == 1), 1'b0, two});
            rd(16'hFF95, 8'h0C);
            rd(16'hFF80, {ad[6:0], dir});
            chk_val(nb[23:0], two ? 24'h3 : 24'h2);
            if (dir) begin
                rd(16'hFF83, rd_data[15:8]);
                if (two) rd(16'hFF84, rd_data[7:0]);
                chk_val({16'h0, rx[7:0]}, {16'h0, ad[6:0], 1'b1});
                chk_val({22'h0, acks & {two, 1'b1}}, 24'h1);
            end else begin
                ew = two ? {ad[6:0], 1'b0, d1, d2} : {8'h0, ad[6:0], 1'b0, d1};
                chk_val(two ? rx : {8'h0, rx[15:0]}, ew);
            end
        end
        repeat (3) @(posedge clock);
        summarize();
    end
endmodule
